/* File: src/clock_pulse_generator_ctrl.sv */
// Clock pulse generator control: registers, power states and clock pin
`default_nettype none
`include "clock_pulse_generator_defs.svh"
module clock_pulse_generator_ctrl
    import clock_pulse_generator_pkg::*;
#(
    parameter int unsigned SETTLE_UNIT =
        (`SETTLE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // AXI4-Lite write address and data
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // Processor power requests, same clock
    input  wire logic        sleep_req_i,
    input  wire logic        standby_enable_i,
    input  wire logic        wake_i,
    input  wire logic        pc_break_i,
    input  wire logic [2:0]  standby_wait_select_i,
    // Hardware standby pin
    input  wire logic        hw_standby_i,
    // Clock generator outputs
    output logic             bus_clk_en_o,
    output logic [1:0]       pll_factor_o,
    output logic             oscillator_run_o,
    output logic             cpu_resume_o,
    output logic             break_exception_o,
    // System clock pin
    output logic             clock_pin_o,
    output logic             clock_pin_oe_o
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [7:0]  sys_clk_ctrl_reg;
    logic [7:0]  low_power_ctrl_reg;
    logic [7:0]  aw_addr_reg;
    logic [7:0]  w_data_reg;
    logic        w_lane0_reg;
    logic        aw_full_reg;
    logic        w_full_reg;
    logic        aw_take;
    logic        w_take;
    logic        commit;
    logic        aw_full_next;
    logic        w_full_next;
    logic        b_next;
    logic        ar_take;
    logic        r_next;
    logic        wr_sys;
    logic        wr_low;
    logic        wr_hit;
    logic        rd_sys;
    logic        rd_low;
    logic [7:0]  rd_byte;
    logic [7:0]  sys_clk_ctrl_next;
    logic [7:0]  low_power_ctrl_next;

    // Handshakes; address and data are held separately, any order
    assign aw_take      = s_axi_awvalid_i & s_axi_awready_o;
    assign w_take       = s_axi_wvalid_i & s_axi_wready_o;
    assign commit       = aw_full_reg & w_full_reg & ~s_axi_bvalid_o;
    assign aw_full_next = (aw_full_reg | aw_take) & ~commit;
    assign w_full_next  = (w_full_reg | w_take) & ~commit;
    assign b_next       = commit | (s_axi_bvalid_o & ~s_axi_bready_i);
    assign ar_take      = s_axi_arvalid_i & s_axi_arready_o;
    assign r_next       = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

    // Address decode
    assign wr_sys  = (aw_addr_reg == `SYS_CLK_CTRL_OFFSET);
    assign wr_low  = (aw_addr_reg == `LOW_POWER_CTRL_OFFSET);
    assign wr_hit  = wr_sys | wr_low;
    assign rd_sys  = (s_axi_araddr_i == `SYS_CLK_CTRL_OFFSET);
    assign rd_low  = (s_axi_araddr_i == `LOW_POWER_CTRL_OFFSET);
    assign rd_byte = rd_sys ? sys_clk_ctrl_reg
                   : rd_low ? low_power_ctrl_reg : 8'h00;

    // Reserved bits never stored, so they read zero
    assign sys_clk_ctrl_next = (commit && wr_sys && w_lane0_reg)
        ? {w_data_reg[`PIN_OFF_BIT], 3'h0,
           w_data_reg[`SWITCH_MODE_BIT:0]}
        : sys_clk_ctrl_reg;
    assign low_power_ctrl_next = (commit && wr_low && w_lane0_reg)
        ? {4'h0, w_data_reg[`LP_RW_MSB:0]}
        : low_power_ctrl_reg;

    // Write channel and registers
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_addr_reg        <= 8'h00;
            w_data_reg         <= 8'h00;
            w_lane0_reg        <= 1'b0;
            aw_full_reg        <= 1'b0;
            w_full_reg         <= 1'b0;
            s_axi_awready_o    <= 1'b1;
            s_axi_wready_o     <= 1'b1;
            s_axi_bvalid_o     <= 1'b0;
            s_axi_bresp_o      <= `RESP_OKAY;
            sys_clk_ctrl_reg   <= `SYS_CLK_CTRL_RESET;
            low_power_ctrl_reg <= `LOW_POWER_CTRL_RESET;
        end
        else
        begin
            if (aw_take)
                aw_addr_reg <= {s_axi_awaddr_i[7:2], 2'h0};
            if (w_take)
            begin
                w_data_reg  <= s_axi_wdata_i[7:0];
                w_lane0_reg <= s_axi_wstrb_i[0];
            end
            if (commit)
                s_axi_bresp_o <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            aw_full_reg        <= aw_full_next;
            w_full_reg         <= w_full_next;
            s_axi_awready_o    <= ~aw_full_next;
            s_axi_wready_o     <= ~w_full_next;
            s_axi_bvalid_o     <= b_next;
            sys_clk_ctrl_reg   <= sys_clk_ctrl_next;
            low_power_ctrl_reg <= low_power_ctrl_next;
        end
    end

    // Read channel; data captured when the address is taken
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= 32'h0000_0000;
            s_axi_rresp_o   <= `RESP_OKAY;
        end
        else
        begin
            if (ar_take)
            begin
                s_axi_rdata_o <= {24'h00_0000, rd_byte};
                s_axi_rresp_o <= (rd_sys | rd_low) ? `RESP_OKAY
                                                   : `RESP_SLVERR;
            end
            s_axi_rvalid_o  <= r_next;
            s_axi_arready_o <= ~r_next;
        end
    end

    // ****************************************************************
    // Power state sequencing
    // ****************************************************************
    power_state_type state_reg;
    power_state_type state_next;
    logic [1:0]  hw_sync_reg;
    logic        hw_standby;
    logic        switch_now;
    logic        written_factor_ok;
    logic        enter_standby;
    logic        settle_start;
    logic        settle_done;
    logic        break_reg;
    logic        break_next;
    logic [1:0]  factor_next;
    logic [31:0] settle_limit;
    logic        gen_running;

    assign hw_standby        = hw_sync_reg[1];
    assign switch_now        = sys_clk_ctrl_reg[`SWITCH_MODE_BIT];
    assign written_factor_ok =
        (low_power_ctrl_reg[`FACTOR_MSB:0] != `FACTOR_BAD);
    assign enter_standby = (state_reg == ST_RUN) && sleep_req_i
                           && standby_enable_i;
    assign settle_start  = (state_next == ST_SETTLE)
                           && (state_reg != ST_SETTLE);
    // Longer wait per code step; a count this size must be shortenable
    assign settle_limit  = 32'(SETTLE_UNIT)
                           * {29'h0, standby_wait_select_i}
                           + 32'(SETTLE_UNIT);
    assign gen_running   = (state_reg == ST_RUN) || (state_reg == ST_SLEEP);

    // Next power state; hardware standby overrides everything
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN:
                if (sleep_req_i)
                    state_next = standby_enable_i ? ST_SW_STANDBY : ST_SLEEP;
            ST_SLEEP:
                if (wake_i)
                    state_next = ST_RUN;
            ST_SW_STANDBY:
                if (wake_i)
                    state_next = ST_SETTLE;
            ST_SETTLE:
                if (settle_done)
                    state_next = ST_RUN;
            ST_HW_STANDBY:
                if (!hw_standby)
                    state_next = ST_SETTLE;
            default:
                state_next = ST_RUN;
        endcase
        if (hw_standby)
            state_next = ST_HW_STANDBY;
    end

    // Break on the standby sleep is kept until the settle wait ends
    assign break_next = (enter_standby && pc_break_i)
                        ? 1'b1
                        : (settle_done ? 1'b0 : break_reg);

    // Active factor: immediate on rewrite, or taken at standby entry
    assign factor_next =
        ((switch_now && written_factor_ok)
         || (!switch_now && enter_standby && written_factor_ok))
        ? low_power_ctrl_reg[`FACTOR_MSB:0]
        : pll_factor_o;

    // Hardware standby pin synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            hw_sync_reg <= 2'h0;
        else
            hw_sync_reg <= {hw_sync_reg[0], hw_standby_i};
    end

    // State, factor and event outputs
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg         <= ST_RUN;
            break_reg         <= 1'b0;
            pll_factor_o      <= `FACTOR_X1;
            oscillator_run_o  <= 1'b1;
            cpu_resume_o      <= 1'b0;
            break_exception_o <= 1'b0;
        end
        else
        begin
            state_reg         <= state_next;
            break_reg         <= break_next;
            pll_factor_o      <= factor_next;
            oscillator_run_o  <= (state_next != ST_SW_STANDBY)
                                 && (state_next != ST_HW_STANDBY);
            cpu_resume_o      <= (settle_done && !break_reg)
                                 || (state_reg == ST_SLEEP && wake_i);
            break_exception_o <= settle_done && break_reg;
        end
    end

    settle_timer u_settle
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .start_i (settle_start),
        .limit_i (settle_limit),
        .done_o  (settle_done)
    );

    // ****************************************************************
    // Bus master clock and clock pin
    // ****************************************************************
    logic phase_reg;
    logic pin_next;

    medium_speed_divider u_divider
    (
        .clk_i           (clk_i),
        .rst_n_i         (rst_n_i),
        .run_i           (gen_running),
        .select_i        (sys_clk_ctrl_reg[`BUS_SEL_MSB:0]),
        .bus_clk_en_o    (bus_clk_en_o),
        .active_select_o ()
    );

    // Pin mirrors the clock as a toggle; held high when stopped
    assign pin_next = (gen_running && !sys_clk_ctrl_reg[`PIN_OFF_BIT])
                      ? ~phase_reg : 1'b1;

    // Pin drive; released only in hardware standby
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phase_reg      <= 1'b1;
            clock_pin_o    <= 1'b1;
            clock_pin_oe_o <= 1'b1;
        end
        else
        begin
            phase_reg      <= pin_next;
            clock_pin_o    <= pin_next;
            clock_pin_oe_o <= (state_next != ST_HW_STANDBY);
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    pin_high_standby_a: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        (state_reg == ST_SW_STANDBY) |=> clock_pin_o)
        else $error("clock pin not high in software standby");
    pin_released_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_HW_STANDBY) |-> !clock_pin_oe_o)
        else $error("clock pin driven in hardware standby");
    reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_axi_rvalid_o |-> (s_axi_rdata_o[6:4] == 3'h0))
        else $error("reserved bits read nonzero");
    factor_defer_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (!switch_now && !enter_standby) |=> $stable(pll_factor_o))
        else $error("deferred factor changed outside standby entry");
    factor_now_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (switch_now && written_factor_ok)
        |=> (pll_factor_o == $past(low_power_ctrl_reg[1:0])))
        else $error("immediate factor not applied");
    factor_legal_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pll_factor_o != `FACTOR_BAD)
        else $error("prohibited factor in use");
    standby_take_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (enter_standby && !switch_now && written_factor_ok && !hw_standby)
        |=> (pll_factor_o == $past(low_power_ctrl_reg[1:0]))
            && !oscillator_run_o)
        else $error("standby entry did not take written factor");
    settle_end_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (settle_done && state_reg == ST_SETTLE && !hw_standby)
        |=> (state_reg == ST_RUN) && (cpu_resume_o ^ break_exception_o))
        else $error("settle end did not resume exactly once");
    low_bits_rw_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (commit && wr_low && w_lane0_reg)
        |=> (low_power_ctrl_reg[3:2] == $past(w_data_reg[3:2])))
        else $error("power bits 3..2 not stored");
    standby_cover_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        enter_standby ##[1:20] (state_reg == ST_SETTLE));
    break_cover_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        break_exception_o);
    sleep_cover_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        (state_reg == ST_SLEEP) ##1 cpu_resume_o);

endmodule
`default_nettype wire

/* File: include/clock_pulse_generator_defs.svh */
// Offsets, field positions, reset values and timing in nanoseconds of the block
`ifndef CLOCK_PULSE_GENERATOR_DEFS_SVH
`define CLOCK_PULSE_GENERATOR_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SYS_CLK_CTRL_OFFSET   8'h00
`define LOW_POWER_CTRL_OFFSET 8'h04

// ****************************************************************
// Field positions
// ****************************************************************
`define PIN_OFF_BIT           7
`define SWITCH_MODE_BIT       3
`define BUS_SEL_MSB           2
`define LP_RW_MSB             3
`define FACTOR_MSB            1

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define SYS_CLK_CTRL_RESET    8'h00
`define LOW_POWER_CTRL_RESET  8'h00
`define FACTOR_X1             2'h0
`define FACTOR_BAD            2'h3
`define SELECT_MAX            3'h5
`define DIV_WRAP              5'h1F
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define SETTLE_UNIT_NS        81920
`define CLK_PERIOD_NS         10

`endif

/* File: include/clock_pulse_generator_pkg.sv */
// Types shared by the clock pulse generator control files
`default_nettype none
package clock_pulse_generator_pkg;

    // Power state of the generator
    typedef enum logic [2:0] {
        ST_RUN        = 3'b000,
        ST_SLEEP      = 3'b001,
        ST_SW_STANDBY = 3'b010,
        ST_SETTLE     = 3'b011,
        ST_HW_STANDBY = 3'b100
    } power_state_type;

endpackage
`default_nettype wire

/* File: src/medium_speed_divider.sv */
// Medium-speed divider and glitch-free bus master clock enable selection
`default_nettype none
`include "clock_pulse_generator_defs.svh"
module medium_speed_divider
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       run_i,
    input  wire logic [2:0] select_i,
    // Enables
    output logic            bus_clk_en_o,
    output logic [2:0]      active_select_o
);

    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic [5:0] tap;
    logic       wrap;
    logic       select_ok;
    logic [2:0] select_next;
    logic       en_next;

    // Tap k is high once every 2**k cycles
    assign tap[0] = 1'b1;
    for (genvar k = 1; k < 6; k++)
    begin : g_tap
        assign tap[k] = &count_reg[k-1:0];
    end

    // Switch only where every divided period ends together
    assign wrap        = (count_reg == `DIV_WRAP);
    assign select_ok   = (select_i <= `SELECT_MAX);
    assign select_next = (wrap && select_ok) ? select_i
                                             : active_select_o;
    assign count_next  = run_i ? count_reg + 5'h01 : count_reg;
    assign en_next     = run_i & tap[active_select_o];

    // Divider state
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_reg       <= 5'h00;
            active_select_o <= 3'h0;
            bus_clk_en_o    <= 1'b1;
        end
        else
        begin
            count_reg       <= count_next;
            active_select_o <= select_next;
            bus_clk_en_o    <= en_next;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    select_legal_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        active_select_o <= `SELECT_MAX)
        else $error("bus clock select holds a prohibited code");
    select_switch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (active_select_o != $past(active_select_o)) |-> $past(wrap))
        else $error("bus clock select changed mid period");
    half_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (active_select_o == 3'h1 && run_i && $past(run_i) && bus_clk_en_o)
        |=> !bus_clk_en_o)
        else $error("half rate enable ran two cycles in a row");

endmodule
`default_nettype wire

/* File: src/settle_timer.sv */
// Oscillation settling wait counter for standby exit
`default_nettype none
module settle_timer
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Control
    input  wire logic        start_i,
    input  wire logic [31:0] limit_i,
    // Status
    output logic             done_o
);

    logic [31:0] count_reg;
    logic        busy_reg;
    logic        last;

    // Last cycle of the wait; a zero limit still takes one cycle
    assign last = busy_reg && (count_reg <= 32'h0000_0001);

    // Countdown
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            count_reg <= 32'h0000_0000;
            busy_reg  <= 1'b0;
            done_o    <= 1'b0;
        end
        else
        begin
            done_o <= last;
            if (start_i)
            begin
                count_reg <= limit_i;
                busy_reg  <= 1'b1;
            end
            else if (last)
                busy_reg <= 1'b0;
            else if (busy_reg)
                count_reg <= count_reg - 32'h0000_0001;
        end
    end

endmodule
`default_nettype wire

/* File: tb/osc_source.sv */
// Behavioural crystal or external clock source on the oscillator input
`default_nettype none
module osc_source
(
    // Oscillator run state seen from the device
    input  wire logic run_i,
    // Oscillator input line
    output var logic  osc_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Toggles while running, parked high in standby so no stray edge leaks
    initial osc_o = 1'b1;
    always #25 osc_o = (run_i === 1'b1) ? ~osc_o : 1'b1;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the clock pulse generator control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SU = 4;
    logic             clk_i = 0, rst_n_i = 0;
    logic [7:0]       aw_a = 0, ar_a = 0;
    logic [31:0]      w_d = 0;
    logic             aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic             sleep = 0, sby = 0, wake = 0, brk = 0, hws = 0;
    logic [2:0]       wsel = 0;
    wire logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, bus_en, osc_run;
    wire logic        resume, brk_exc, pin, pin_oe, osc_line;
    wire logic [1:0]  b_resp, r_resp, pll;
    wire logic [31:0] r_d;
    int               errors = 0, n_tests = 0;
    // ****************************************************************
    // Design, far-side source and clock
    // ****************************************************************
    clock_pulse_generator_ctrl #(.SETTLE_UNIT(SU)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(aw_a),
        .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
        .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(w_v),
        .s_axi_wready_o(w_rdy), .s_axi_bresp_o(b_resp),
        .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
        .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v),
        .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_d),
        .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_v),
        .s_axi_rready_i(r_r), .sleep_req_i(sleep),
        .standby_enable_i(sby), .wake_i(wake), .pc_break_i(brk),
        .standby_wait_select_i(wsel), .hw_standby_i(hws),
        .bus_clk_en_o(bus_en), .pll_factor_o(pll),
        .oscillator_run_o(osc_run), .cpu_resume_o(resume),
        .break_exception_o(brk_exc), .clock_pin_o(pin),
        .clock_pin_oe_o(pin_oe));
    osc_source src (.run_i(osc_run), .osc_o(osc_line));
    always #5 clk_i = ~clk_i;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    function automatic logic [31:0] exp_pulses(input logic [2:0] s);
        return 32'd64 >> s;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] rsp);
        @(posedge clk_i);
        aw_a <= a;
        w_d <= {24'h0, d};
        aw_v <= 1;
        w_v <= 1;
        b_r <= 1;
        fork
            begin do @(posedge clk_i); while (aw_rdy !== 1'b1); aw_v <= 0; end
            begin do @(posedge clk_i); while (w_rdy !== 1'b1); w_v <= 0; end
        join
        do @(posedge clk_i); while (b_v !== 1'b1);
        rsp = b_resp;
        b_r <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] rsp);
        @(posedge clk_i);
        ar_a <= a;
        ar_v <= 1;
        r_r <= 1;
        do @(posedge clk_i); while (ar_rdy !== 1'b1);
        ar_v <= 0;
        do @(posedge clk_i); while (r_v !== 1'b1);
        d = r_d;
        rsp = r_resp;
        r_r <= 0;
    endtask
    // Sleep into software standby, wake, then time the settling wait
    task automatic standby(input logic pb, input logic [2:0] code,
                           input logic [1:0] fexp);
        int n;
        @(posedge clk_i);
        wsel <= code;
        sby <= 1;
        brk <= pb;
        sleep <= 1;
        @(posedge clk_i);
        sleep <= 0;
        repeat (3) @(posedge clk_i);
        chk(osc_run, 0);
        chk(pin, 1);
        chk(pll, fexp);
        chk(osc_line, 1);
        wake <= 1;
        @(posedge clk_i);
        wake <= 0;
        n = 0;
        do begin @(posedge clk_i); n++; end
        while (resume !== 1'b1 && brk_exc !== 1'b1 && n < 200);
        chk(brk_exc, pb);
        chk(resume, !pb);
        chk(n >= SU * (code + 1), 1);
        chk(n < SU * (code + 1) + 8, 1);
        chk(pll, fexp);
    endtask
    task automatic end_of_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial
    begin
        logic [1:0]  rsp, f, act;
        logic [31:0] d;
        logic [7:0]  v;
        logic [2:0]  sel;
        int          cnt, tog;
        logic        prev;
        void'($urandom(65426));
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1;
        chk(pll, 0);
        chk(bus_en, 1);
        // Reserved bits, stored bits and two unmapped places
        repeat (4)
        begin
            v = 8'($urandom);
            wr(8'h00, v, rsp);
            rd(8'h00, d, rsp);
            chk(d, {24'h0, v & 8'h8F});
            v = 8'($urandom) & 8'h0F;
            wr(8'h04, v, rsp);
            rd(8'h04, d, rsp);
            chk(d, {24'h0, v});
        end
        wr(8'h08, 8'hFF, rsp);
        chk(rsp, 2'h2);
        rd(8'h0C, d, rsp);
        chk(rsp, 2'h2);
        chk(d, 0);
        // Immediate mode: every factor code, the prohibited one kept out
        wr(8'h00, 8'h08, rsp);
        wr(8'h04, 8'h00, rsp);
        act = 0;
        for (int i = 0; i < 6; i++)
        begin
            f = (i < 4) ? i[1:0] : 2'($urandom);
            wr(8'h04, {6'h0, f}, rsp);
            repeat (2) @(posedge clk_i);
            if (f != 2'h3) act = f;
            chk(pll, act);
        end
        // Deferred mode: factor applies only through standby
        wr(8'h00, 8'h00, rsp);
        for (int i = 0; i < 3; i++)
        begin
            f = 2'($urandom_range(2));
            wr(8'h04, {6'h0, f}, rsp);
            chk(pll, act);
            act = f;
            standby(i[0], 3'($urandom), act);
        end
        // Every select code, prohibited ones keep the old divider
        sel = 0;
        for (int i = 0; i < 10; i++)
        begin
            v = {1'($urandom), 4'h0, (i < 8) ? i[2:0] : 3'($urandom)};
            wr(8'h00, v, rsp);
            if (v[2:0] <= 3'h5) sel = v[2:0];
            repeat (40) @(posedge clk_i);
            cnt = 0;
            tog = 0;
            prev = pin;
            repeat (64)
            begin
                @(posedge clk_i);
                cnt += (bus_en === 1'b1);
                tog += (pin !== prev);
                prev = pin;
            end
            chk(cnt, exp_pulses(sel));
            chk(tog, v[7] ? 0 : 64);
        end
        // Sleep keeps the generator and pin running; wake resumes at once
        sby <= 0;
        sleep <= 1;
        @(posedge clk_i);
        sleep <= 0;
        @(posedge clk_i);
        prev = pin;
        chk(osc_run, 1);
        wake <= 1;
        @(posedge clk_i);
        wake <= 0;
        chk(pin !== prev, !v[7]);
        @(posedge clk_i);
        chk(resume, 1);
        // Hardware standby releases the pin, exit settles and resumes
        hws <= 1;
        repeat (4) @(posedge clk_i);
        chk(pin_oe, 0);
        hws <= 0;
        cnt = 0;
        do begin @(posedge clk_i); cnt++; end
        while (resume !== 1'b1 && cnt < 200);
        chk(resume, 1);
        chk(pin_oe, 1);
        end_of_test();
    end
    initial
    begin
        #300000;
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
